// ### common/tmr_pkg.sv
// Purpose: constants shared by the timer/counter block and its synchroniser
// Assumes: 32-bit Avalon-MM register word, byte addresses
// Notes:   one place for offsets, field positions and reset values
package tmr_pkg;
   // register byte offsets
   localparam logic [3:0] ADDR_OPTION  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_COUNT   = 4'h8;
   localparam int         ADDR_W       = 4;
   localparam int         DATA_W       = 32;

   // option register fields
   localparam int OPT_RATE_LSB   = 0;
   localparam int OPT_RATE_W     = 3;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_EDGE_BIT   = 4;
   localparam int OPT_SOURCE_BIT = 5;
   localparam int OPT_W          = 6;
   localparam logic [5:0] OPT_RESET = 6'h3F;

   // control register fields
   localparam int CTL_FLAG_BIT   = 2;
   localparam int CTL_ENABLE_BIT = 5;

   // counter widths and reset values
   localparam int         COUNT_W      = 8;
   localparam int         DIV_W        = 8;
   localparam logic [7:0] COUNT_RESET  = 8'h00;
   localparam logic [7:0] COUNT_MAX    = 8'hFF;
   localparam logic [7:0] DIV_RESET    = 8'h00;

   // instruction cycle of four phase clocks
   localparam int         PHASES       = 4;
   localparam logic [1:0] PHASE_TWO    = 2'h1;
   localparam logic [1:0] PHASE_FOUR   = 2'h3;

   // cycles without counting after a count write
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

   // synchroniser reset level
   localparam logic SYNC_RESET = 1'b0;
endpackage : tmr_pkg

// ### design/tmr_sync3.sv
// Purpose: three-flop synchroniser for the external count pin
// Assumes: pin is asynchronous to clk_sys_i
// Notes:   output changes only when the second and third flops agree
`timescale 1ns/100ps
`default_nettype none
module tmr_sync3
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // asynchronous pin and clean level
   input  wire logic pin_i,
   output logic      level_o
);
   logic stage1;
   logic stage2;
   logic stage3;
   wire  agree = (stage2 == stage3);

   // stage1 feeds stage2 only, metastability stays contained
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stage1  <= SYNC_RESET;
         stage2  <= SYNC_RESET;
         stage3  <= SYNC_RESET;
         level_o <= SYNC_RESET;
      end else begin
         stage1  <= pin_i;
         stage2  <= stage1;
         stage3  <= stage2;
         if (agree) begin
            level_o <= stage3;
         end
      end
   end
endmodule : tmr_sync3
`default_nettype wire

// ### design/tmr_timer0.sv
// Purpose: 8-bit timer/counter with a divider shared with the watchdog
// Assumes: instruction cycle is four clk_sys_i phases generated here
// Notes:   registers reached over Avalon-MM with one wait state
// Function
// - timer mode counts each instruction cycle when the divider is elsewhere
// - count write suppresses counting two instruction cycles, then resumes
// - counter mode counts external pin edges instead of instruction cycles
// - edge select 0 counts rising edges, 1 counts falling edges
// - wrap from all ones to zero sets the overflow flag
// - enable bit gates the interrupt request; flag still sets when masked
// - flag stays set until software writes zero; software clears before re-enabling
// - sleep stops the timer, so no overflow request during sleep
// - external path sampled in phase two and phase four
// - one 8-bit divider, prescaler for timer or postscaler for watchdog
// - assignment bit 0 gives divider to timer, 1 to watchdog
// - three-bit rate field selects division ratio
// - divider count not visible or loadable through registers
// - count write clears divider while divider belongs to timer
// - watchdog clear resets divider while divider belongs to watchdog
`timescale 1ns/100ps
`default_nettype none
module tmr_timer0
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [DATA_W-1:0] avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [DATA_W-1:0]      avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // external count pin
   input  wire logic              external_count_pin_i,
   // core and watchdog side
   input  wire logic              sleep_i,
   input  wire logic              watchdog_tick_i,
   input  wire logic              watchdog_clear_instr_i,
   output logic                   watchdog_post_tick_o,
   // overflow request to the interrupt controller
   output logic                   overflow_irq_o
);
   // scaler mask: low bits that must be all ones for one output tick
   function automatic logic [DIV_W-1:0] rate_mask(input logic [OPT_RATE_W-1:0] rate,
                                                  input logic to_watchdog);
      logic [DIV_W:0] full;
      full = '0;
      if (to_watchdog) begin
         full = (9'h001 << rate) - 9'h001;
      end else begin
         full = (9'h002 << rate) - 9'h001;
      end
      return full[DIV_W-1:0];
   endfunction : rate_mask

   // state
   logic [OPT_W-1:0]   option_reg;
   logic               overflow_flag;
   logic               overflow_irq_enable;
   logic [COUNT_W-1:0] count_register;
   logic [DIV_W-1:0]   div_cnt;
   logic [1:0]         phase;
   logic [1:0]         inhibit_cnt;
   logic               ack;
   logic               pin_level;
   logic               pin_smp;
   logic               pin_prev;
   logic               smp_new;
   logic               wdt_post;

   // option fields
   wire [OPT_RATE_W-1:0] divider_rate        = option_reg[OPT_RATE_LSB +: OPT_RATE_W];
   wire                  divider_assignment  = option_reg[OPT_ASSIGN_BIT];
   wire                  count_edge_select   = option_reg[OPT_EDGE_BIT];
   wire                  count_source_select = option_reg[OPT_SOURCE_BIT];

   // bus decode; one wait state so readdata can be registered
   wire access     = avs_read_i | avs_write_i;
   wire accept     = access & ack;
   wire wr_lane0   = accept & avs_write_i & avs_byteenable_i[0];
   wire wr_option  = wr_lane0 & (avs_address_i == ADDR_OPTION);
   wire wr_control = wr_lane0 & (avs_address_i == ADDR_CONTROL);
   wire wr_count   = wr_lane0 & (avs_address_i == ADDR_COUNT);
   wire rd_capture = avs_read_i & ~ack; // read sampled in the wait cycle
   assign avs_waitrequest_o = access & ~ack;

   // read mux; divider count has no address at all
   wire [DATA_W-1:0] rd_option  = {{(DATA_W-OPT_W){1'b0}}, option_reg};
   wire [DATA_W-1:0] rd_control = {{(DATA_W-CTL_ENABLE_BIT-1){1'b0}}, overflow_irq_enable,
                                   2'b00, overflow_flag, 2'b00};
   wire [DATA_W-1:0] rd_count   = {{(DATA_W-COUNT_W){1'b0}}, count_register};
   wire [DATA_W-1:0] rd_mux     = (avs_address_i == ADDR_OPTION)  ? rd_option  :
                                  (avs_address_i == ADDR_CONTROL) ? rd_control :
                                  (avs_address_i == ADDR_COUNT)   ? rd_count   :
                                  {DATA_W{1'b0}};

   // phase decode
   wire in_phase_two  = (phase == PHASE_TWO);
   wire in_phase_four = (phase == PHASE_FOUR);
   wire instr_end     = in_phase_four;

   // external edge from samples taken in phase two and phase four
   wire ext_rise  = smp_new & ~pin_prev & pin_smp;
   wire ext_fall  = smp_new & pin_prev & ~pin_smp;
   wire ext_edge  = count_edge_select ? ext_fall : ext_rise;

   // raw source tick: instruction cycles or pin edges, none in sleep
   wire src_tick  = ~sleep_i & (count_source_select ? ext_edge : instr_end);

   // shared divider input and hit
   wire [DIV_W-1:0] mask = rate_mask(divider_rate, divider_assignment);
   wire div_in    = divider_assignment ? watchdog_tick_i : src_tick;
   wire div_hit   = div_in & ((div_cnt & mask) == mask);
   wire div_clear = (wr_count & ~divider_assignment) |
                    (watchdog_clear_instr_i & divider_assignment);
   wire [DIV_W-1:0] next_div = div_clear ? DIV_RESET :
                               div_in    ? div_cnt + 8'h01 : div_cnt;

   // timer tick: straight when divider is elsewhere, else scaled
   wire timer_tick = divider_assignment ? src_tick : (div_hit & ~sleep_i);
   wire count_inc  = timer_tick & (inhibit_cnt == 2'h0) & ~wr_count & ~sleep_i;
   wire wrap       = count_inc & (count_register == COUNT_MAX);

   // inhibit countdown on instruction cycles
   wire [1:0] next_inhibit = wr_count ? INHIBIT_CYCLES :
                             (instr_end & (inhibit_cnt != 2'h0)) ? inhibit_cnt - 2'h1 :
                             inhibit_cnt;

   // flag: hardware set wins over a software clear
   wire next_flag = wrap | (wr_control ? avs_writedata_i[CTL_FLAG_BIT] : overflow_flag);

   // request only while enabled; flag sets regardless
   assign overflow_irq_o = overflow_flag & overflow_irq_enable;
   assign watchdog_post_tick_o = wdt_post;

   // external pin synchroniser
   tmr_sync3 u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     (external_count_pin_i),
      .level_o   (pin_level)
   );

   // bus handshake and read data
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ack            <= 1'b0;
         avs_readdata_o <= '0;
      end else begin
         ack <= access & ~ack;
         // captured one edge early so the data stand at the accepting edge
         if (rd_capture) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   // software-owned configuration
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         option_reg          <= OPT_RESET;
         overflow_irq_enable <= 1'b0;
      end else begin
         if (wr_option) begin
            option_reg <= avs_writedata_i[OPT_W-1:0];
         end
         if (wr_control) begin
            overflow_irq_enable <= avs_writedata_i[CTL_ENABLE_BIT];
         end
      end
   end

   // phase clock and pin sampling
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         phase    <= 2'h0;
         pin_smp  <= 1'b0;
         pin_prev <= 1'b0;
         smp_new  <= 1'b0;
      end else begin
         phase   <= phase + 2'h1;
         smp_new <= in_phase_two | in_phase_four;
         if (in_phase_two | in_phase_four) begin
            pin_smp  <= pin_level;
            pin_prev <= pin_smp;
         end
      end
   end

   // count, flag, divider
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         count_register <= COUNT_RESET;
         overflow_flag  <= 1'b0;
         div_cnt        <= DIV_RESET;
         inhibit_cnt    <= 2'h0;
         wdt_post       <= 1'b0;
      end else begin
         if (wr_count) begin
            count_register <= avs_writedata_i[COUNT_W-1:0];
         end else if (count_inc) begin
            count_register <= count_register + 8'h01;
         end
         overflow_flag <= next_flag;
         div_cnt       <= next_div;
         inhibit_cnt   <= next_inhibit;
         // watchdog sees scaled ticks only while it owns the divider
         wdt_post      <= divider_assignment & div_hit & ~div_clear;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_count_write;
      wr_count;
   endsequence

   sequence s_inhibit_window;
      (inhibit_cnt != 2'h0) [*4];
   endsequence

   a_count_load: assert property (
      s_count_write |=> count_register == $past(avs_writedata_i[COUNT_W-1:0]))
      else $error("count write not loaded");

   a_inhibit_after_write: assert property (
      s_count_write |=> s_inhibit_window)
      else $error("inhibit ended too soon after count write");

   a_inhibit_blocks: assert property (
      (inhibit_cnt != 2'h0) && !wr_count |=> $stable(count_register))
      else $error("count moved while inhibited");

   a_timer_mode_rate: assert property (
      !count_source_select && divider_assignment && instr_end && !sleep_i
      && inhibit_cnt == 2'h0 && !wr_count |=> count_register == $past(count_register) + 8'h01)
      else $error("timer mode missed an instruction cycle");

   a_ext_edge_count: assert property (
      count_source_select && divider_assignment && ext_edge && !sleep_i
      && inhibit_cnt == 2'h0 && !wr_count |-> count_inc)
      else $error("external edge not counted");

   a_wrap_sets_flag: assert property (
      wrap |=> overflow_flag && count_register == COUNT_RESET)
      else $error("wrap did not set flag");

   a_flag_sticky: assert property (
      overflow_flag && !(wr_control && !avs_writedata_i[CTL_FLAG_BIT]) |=> overflow_flag)
      else $error("flag dropped without software clear");

   a_irq_masked: assert property (
      !overflow_irq_enable |-> !overflow_irq_o)
      else $error("request raised while masked");

   a_sleep_freeze: assert property (
      sleep_i && !wr_count |=> $stable(count_register) && !$rose(overflow_flag))
      else $error("timer moved during sleep");

   a_div_clear_timer: assert property (
      wr_count && !divider_assignment |=> div_cnt == DIV_RESET)
      else $error("count write did not clear divider");

   a_div_clear_wdt: assert property (
      watchdog_clear_instr_i && divider_assignment |=> div_cnt == DIV_RESET)
      else $error("watchdog clear did not clear divider");

   a_ratio_timer: assert property (
      !divider_assignment && !sleep_i && src_tick && !div_clear && divider_rate == 3'h0
      && div_cnt[0] |-> div_hit)
      else $error("timer divide-by-two ratio wrong");

   // bus path: exactly one wait state, read data stand at the accepting edge
   sequence s_count_read;
      rd_capture && (avs_address_i == ADDR_COUNT);
   endsequence

   a_bus_one_wait: assert property (
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("more than one wait state");

   a_read_count: assert property (
      s_count_read |=> avs_readdata_o[COUNT_W-1:0] == $past(count_register))
      else $error("count read returned a stale value");

   a_read_upper_zero: assert property (
      rd_capture |=> avs_readdata_o[DATA_W-1:COUNT_W] == '0)
      else $error("upper read bits not zero");

   // flag and request; a masked wrap must still leave the flag behind
   a_flag_set_masked: assert property (
      wrap && !overflow_irq_enable && !wr_control
      |=> overflow_flag && !overflow_irq_o)
      else $error("masked wrap lost the flag or raised a request");

   a_irq_follows: assert property (
      overflow_flag && overflow_irq_enable |-> overflow_irq_o)
      else $error("enabled flag gave no request");

   a_sleep_no_request: assert property (
      sleep_i && !wr_control && !overflow_irq_o |=> !overflow_irq_o)
      else $error("request raised during sleep");

   // counting source and edge choice
   a_timer_ignores_pin: assert property (
      !count_source_select && !instr_end && !wr_count |=> $stable(count_register))
      else $error("timer mode counted outside an instruction cycle end");

   a_rise_ignored: assert property (
      count_source_select && count_edge_select && ext_rise && !wr_count
      |=> $stable(count_register))
      else $error("rising edge counted in falling mode");

   a_fall_ignored: assert property (
      count_source_select && !count_edge_select && ext_fall && !wr_count
      |=> $stable(count_register))
      else $error("falling edge counted in rising mode");

   a_pin_sampled: assert property (
      count_source_select && divider_assignment && count_inc |-> smp_new)
      else $error("pin count outside a sampling phase");

   // shared divider: one owner at a time, moved only by ticks and clears
   a_timer_scaled: assert property (
      !divider_assignment && count_inc |-> div_hit)
      else $error("timer stepped without a divider output");

   a_post_owner: assert property (
      !divider_assignment |=> !watchdog_post_tick_o)
      else $error("watchdog tick while divider belongs to the timer");

   a_post_every_tick: assert property (
      divider_assignment && watchdog_tick_i && divider_rate == 3'h0
      && !watchdog_clear_instr_i |=> watchdog_post_tick_o)
      else $error("watchdog ratio one missed a tick");

   a_div_sleep: assert property (
      sleep_i && !divider_assignment && !div_clear |=> $stable(div_cnt))
      else $error("timer divider moved during sleep");

   a_div_no_load: assert property (
      !div_clear && !div_in |=> $stable(div_cnt))
      else $error("divider moved without a tick or clear");
endmodule : tmr_timer0
`default_nettype wire

// ### verification/tmr_far_side.sv
// Purpose: far side model: external count pin and watchdog strobes
// Assumes: strobes share the block clock; the pin is driven like a real source
// Notes:   each pin level stands 16 clocks, above the 4 the synchroniser needs
`timescale 1ns/100ps
`default_nettype none
module tmr_far_side (
   // clock
   input  wire logic clk_sys_i,
   // pin and watchdog strobes
   output logic      pin_o,
   output logic      tick_o,
   output logic      clear_o,
   // scaled tick returned by the block
   input  wire logic post_tick_i
);
   int post_count = 0;

   // quiet lines from time zero
   initial begin
      pin_o   = 1'b0;
      tick_o  = 1'b0;
      clear_o = 1'b0;
   end

   // running tally of scaled ticks; the bench reads differences
   always @(posedge clk_sys_i) begin
      if (post_tick_i === 1'b1)
         post_count <= post_count + 1;
   end

   // level held long enough to pass the synchroniser and be counted
   task automatic pin_level(input logic v);
      @(posedge clk_sys_i);
      pin_o <= v;
      repeat (16) @(posedge clk_sys_i);
   endtask : pin_level

   // one-cycle strobes with idle gaps, clear or tick
   task automatic pulse(input logic clr, input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         clear_o <= clr;
         tick_o  <= ~clr;
         @(posedge clk_sys_i);
         clear_o <= 1'b0;
         tick_o  <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
      end
   endtask : pulse
endmodule : tmr_far_side
`default_nettype wire

// ### verification/tb_timer0_with_shared_prescaler.sv
// Purpose: self-checking bench for the timer/counter and shared divider
// Assumes: one wait state per access, four clocks per instruction cycle
// Notes:   timer counts are checked in windows since the hold-off length is loose
`timescale 1ns/100ps
`default_nettype none
module tb_timer0_with_shared_prescaler
   import tmr_pkg::*;
;
   logic              clk_sys_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [ADDR_W-1:0] avs_address_i = '0;
   logic              avs_read_i = 1'b0;
   logic              avs_write_i = 1'b0;
   logic [DATA_W-1:0] avs_writedata_i = '0;
   logic [3:0]        avs_byteenable_i = 4'hF;
   logic [DATA_W-1:0] avs_readdata_o;
   logic              avs_waitrequest_o;
   logic              sleep_i = 1'b0;
   logic              pin;
   logic              tick;
   logic              wclr;
   logic              post_tick;
   logic              overflow_irq_o;
   logic [DATA_W-1:0] rd;
   int                fail_count = 0;
   int                checked = 0;
   int                cycles = 0;
   int                base = 0;

   // 125 MHz system clock
   initial forever #4 clk_sys_i = ~clk_sys_i;

   tmr_timer0 u_tmr_timer0 (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .external_count_pin_i(pin),
      .sleep_i(sleep_i), .watchdog_tick_i(tick), .watchdog_clear_instr_i(wclr),
      .watchdog_post_tick_o(post_tick), .overflow_irq_o(overflow_irq_o));

   tmr_far_side u_tmr_far_side (.clk_sys_i(clk_sys_i), .pin_o(pin), .tick_o(tick),
      .clear_o(wclr), .post_tick_i(post_tick));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic fail(input string w);
      fail_count++;
      $display("[FAIL] %0t %s", $time, w);
   endtask : fail

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string w);
      checked++;
      if (got !== exp)
         fail(w);
   endtask : check_val

   // request held until waitrequest is sampled low, data taken at that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'hF);
      @(posedge clk_sys_i);
      avs_address_i    <= a;
      avs_writedata_i  <= {24'h00_0000, d};
      avs_byteenable_i <= be;
      avs_read_i       <= ~wr;
      avs_write_i      <= wr;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string w);
      bus(1'b0, a, 8'h00);
      check_val(rd, exp, w);
   endtask : rd_chk

   // window compare: the hold-off after a write is not pinned to one cycle
   task automatic rd_rng(input logic [3:0] a, input int lo, input int hi, input string w);
      bus(1'b0, a, 8'h00);
      checked++;
      if (((rd >= lo) && (rd <= hi)) !== 1'b1)
         fail(w);
   endtask : rd_rng

   // hang guard, well above the roughly 750 cycles the tests take
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fail("timeout");
         final_report();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd_chk(ADDR_OPTION, 32'(OPT_RESET), "option reset");
      rd_chk(ADDR_CONTROL, 32'h0000_0000, "control reset");
      rd_chk(ADDR_COUNT, 32'(COUNT_RESET), "count reset");
      bus(1'b1, 4'hC, 8'hFF);
      rd_chk(4'hC, 32'h0000_0000, "unmapped");
      $display("test reset done");
      // sleep freezes the count; a write with byte lane off is dropped
      sleep_i <= 1'b1;
      bus(1'b1, ADDR_OPTION, 8'h08);
      bus(1'b1, ADDR_COUNT, 8'h40);
      repeat (60) @(posedge clk_sys_i);
      rd_chk(ADDR_COUNT, 32'h0000_0040, "sleep count");
      bus(1'b1, ADDR_COUNT, 8'h77, 4'h0);
      rd_chk(ADDR_COUNT, 32'h0000_0040, "byte lane");
      sleep_i <= 1'b0;
      $display("test sleep done");
      // hold-off after a count write, then one step per instruction cycle
      bus(1'b1, ADDR_COUNT, 8'h20);
      rd_chk(ADDR_COUNT, 32'h0000_0020, "hold-off");
      repeat (36) @(posedge clk_sys_i);
      rd_rng(ADDR_COUNT, 'h25, 'h2A, "timer rate");
      // divider ahead of the timer: ratio two, then ratio 256
      bus(1'b1, ADDR_OPTION, 8'h00);
      bus(1'b1, ADDR_COUNT, 8'h00);
      repeat (76) @(posedge clk_sys_i);
      rd_rng(ADDR_COUNT, 7, 10, "ratio two");
      bus(1'b1, ADDR_OPTION, 8'h07);
      bus(1'b1, ADDR_COUNT, 8'h00);
      repeat (76) @(posedge clk_sys_i);
      rd_chk(ADDR_COUNT, 32'h0000_0000, "ratio 256");
      $display("test timer done");
      // flag masked, held, cleared by software, then raised as a request
      bus(1'b1, ADDR_OPTION, 8'h08);
      bus(1'b1, ADDR_COUNT, 8'hFE);
      repeat (30) @(posedge clk_sys_i);
      rd_chk(ADDR_CONTROL, 32'h0000_0004, "flag set");
      check_val(32'(overflow_irq_o), 32'h0000_0000, "masked");
      repeat (20) @(posedge clk_sys_i);
      rd_chk(ADDR_CONTROL, 32'h0000_0004, "flag held");
      bus(1'b1, ADDR_CONTROL, 8'h00);
      rd_chk(ADDR_CONTROL, 32'h0000_0000, "flag clear");
      bus(1'b1, ADDR_CONTROL, 8'h20);
      bus(1'b1, ADDR_COUNT, 8'hFE);
      repeat (30) @(posedge clk_sys_i);
      check_val(32'(overflow_irq_o), 32'h0000_0001, "request");
      rd_chk(ADDR_CONTROL, 32'h0000_0024, "flag enabled");
      bus(1'b1, ADDR_CONTROL, 8'h00);
      @(posedge clk_sys_i);
      check_val(32'(overflow_irq_o), 32'h0000_0000, "request gone");
      $display("test overflow done");
      // pin edges: rising mode then falling mode, divider elsewhere
      bus(1'b1, ADDR_OPTION, 8'h28);
      bus(1'b1, ADDR_COUNT, 8'h00);
      repeat (12) @(posedge clk_sys_i);
      u_tmr_far_side.pin_level(1'b1);
      rd_chk(ADDR_COUNT, 32'h0000_0001, "rise");
      u_tmr_far_side.pin_level(1'b0);
      rd_chk(ADDR_COUNT, 32'h0000_0001, "no fall");
      bus(1'b1, ADDR_OPTION, 8'h38);
      bus(1'b1, ADDR_COUNT, 8'h00);
      repeat (12) @(posedge clk_sys_i);
      u_tmr_far_side.pin_level(1'b1);
      rd_chk(ADDR_COUNT, 32'h0000_0000, "no rise");
      u_tmr_far_side.pin_level(1'b0);
      rd_chk(ADDR_COUNT, 32'h0000_0001, "fall");
      $display("test counter done");
      // divider behind the watchdog, one scaled tick per 2^n ticks
      for (int n = 0; n < 3; n++) begin
         bus(1'b1, ADDR_OPTION, 8'h08 | 8'(n));
         u_tmr_far_side.pulse(1'b1, 1);
         base = u_tmr_far_side.post_count;
         u_tmr_far_side.pulse(1'b0, 8);
         repeat (4) @(posedge clk_sys_i);
         check_val(u_tmr_far_side.post_count - base, 8 >> n, "post ratio");
      end
      // clear part way: without it six ticks would give one scaled tick
      bus(1'b1, ADDR_OPTION, 8'h0A);
      u_tmr_far_side.pulse(1'b1, 1);
      base = u_tmr_far_side.post_count;
      u_tmr_far_side.pulse(1'b0, 3);
      u_tmr_far_side.pulse(1'b1, 1);
      u_tmr_far_side.pulse(1'b0, 3);
      repeat (4) @(posedge clk_sys_i);
      check_val(u_tmr_far_side.post_count - base, 0, "cleared");
      u_tmr_far_side.pulse(1'b0, 1);
      repeat (4) @(posedge clk_sys_i);
      check_val(u_tmr_far_side.post_count - base, 1, "after clear");
      $display("test watchdog done");
      final_report();
   end
endmodule : tb_timer0_with_shared_prescaler
`default_nettype wire
